// File: src/serial_link_rx_status_monitor.sv
`timescale 1ns/1ns

module serial_link_rx_status_monitor
  import rx_status_pkg::*;
(
  input  wire logic                                 MCLK,
  input  wire logic                                 RSTN,
  // Register access from the serial control port
  input  wire logic [rx_status_pkg::ADDR_W-1:0]     REG_ADDR,
  input  wire logic [rx_status_pkg::DATA_W-1:0]     REG_WDATA,
  input  wire logic                                 REG_WR,
  input  wire logic                                 REG_RD,
  output logic      [rx_status_pkg::DATA_W-1:0]     REG_RDATA,
  // Lane status from the deframers
  input  wire logic [rx_status_pkg::NUM_LANES-1:0]  LANE_BAD_CTRL_CHAR,
  input  wire logic [rx_status_pkg::NUM_LANES-1:0]  CODE_GROUP_LOCK,
  input  wire logic [rx_status_pkg::NUM_LANES-1:0]  FRAME_ALIGNMENT_LOCK,
  input  wire logic [rx_status_pkg::NUM_LANES-1:0]  CHECKSUM_DONE,
  input  wire logic [rx_status_pkg::NUM_LANES-1:0]  CHECKSUM_OK,
  input  wire logic [rx_status_pkg::NUM_LANES-1:0]  LANE_ALIGNMENT_LOCK,
  // Settings held outside this block
  input  wire logic [rx_status_pkg::DATA_W-1:0]     ERROR_COUNT_LIMIT,
  input  wire logic                                 BAD_CTRL_CHAR_IRQ_ENABLE,
  input  wire logic                                 CODE_GROUP_IRQ_ENABLE,
  // Outputs
  output logic                                      IRQ_N,
  output logic      [3:0]                           IRQ_FLAGS,
  output logic      [rx_status_pkg::NUM_LANES-1:0]  UNEXPECTED_CTRL_CHAR_STATUS,
  output logic                                      LINK_RESYNC_REQUEST_OUT_N,
  output logic                                      FRAME_RESTART,
  output logic      [rx_status_pkg::DATA_W-1:0]     OCTETS_PER_FRAME,
  output logic                                      FRAME_START
);

  import rx_status_pkg::*;

  // ==========================================================
  // Helpers

  // One-hot lane mask, empty when the command bit is not set
  function automatic logic [NUM_LANES-1:0] lane_onehot(
    input logic [LANE_SEL_W-1:0] sel,
    input logic                  en
  );
    logic [NUM_LANES-1:0] mask;
    mask      = '0;
    mask[sel] = en;
    return mask;
  endfunction

  // ==========================================================
  // Write decode

  logic                  wr_cmd;
  logic                  wr_cg;
  logic                  wr_fa;
  logic                  wr_chk;
  logic                  wr_la;
  logic                  wr_ctrl;
  logic [LANE_SEL_W-1:0] command_lane_select;
  logic [NUM_LANES-1:0]  clear_lane_interrupt;
  logic [NUM_LANES-1:0]  disable_lane_error_counter;
  logic [NUM_LANES-1:0]  reset_lane_error_counter;
  logic [NUM_LANES-1:0]  unexpected_ctrl_char_status;

  // Command bits act only in the write cycle and are never stored
  assign wr_cmd  = REG_WR && (REG_ADDR == ADDR_BAD_CTRL_CHAR);
  assign wr_cg   = REG_WR && (REG_ADDR == ADDR_CODE_GROUP);
  assign wr_fa   = REG_WR && (REG_ADDR == ADDR_FRAME_ALIGN);
  assign wr_chk  = REG_WR && (REG_ADDR == ADDR_CHECKSUM);
  assign wr_la   = REG_WR && (REG_ADDR == ADDR_LANE_ALIGN);
  assign wr_ctrl = REG_WR && (REG_ADDR == ADDR_FRAMING_CTRL);

  // Reserved command bits 4:3 are ignored
  assign command_lane_select = REG_WDATA[CMD_LANE_LSB +: LANE_SEL_W];
  assign clear_lane_interrupt =
    lane_onehot(command_lane_select, wr_cmd && REG_WDATA[CMD_CLEAR_BIT]);
  assign disable_lane_error_counter =
    lane_onehot(command_lane_select, wr_cmd && REG_WDATA[CMD_DISABLE_BIT]);
  assign reset_lane_error_counter =
    lane_onehot(command_lane_select, wr_cmd && REG_WDATA[CMD_RESET_BIT]);

  // ==========================================================
  // Per-lane unexpected control character counters

  // A limit of zero is never met by an increment, so that lane never flags
  for (genvar g = 0; g < NUM_LANES; g++)
  begin : g_lane
    logic [7:0] cnt_ff;
    logic [7:0] nxt_cnt;
    logic       dis_ff;
    logic       nxt_dis;
    logic       sts_ff;
    logic       nxt_sts;

    // Status sets on the count step that meets the limit, so a clear
    // is not undone at once by a count already sitting at the limit
    always_comb
    begin
      nxt_cnt = cnt_ff;
      nxt_dis = dis_ff;
      nxt_sts = sts_ff;
      if (clear_lane_interrupt[g])
      begin
        nxt_sts = 1'b0;
      end
      if (reset_lane_error_counter[g])
      begin
        nxt_cnt = COUNT_RESET;
        nxt_dis = 1'b0;
      end
      else if (LANE_BAD_CTRL_CHAR[g] && !dis_ff && (cnt_ff != COUNT_MAX))
      begin
        nxt_cnt = cnt_ff + 8'h01;
        if (nxt_cnt == ERROR_COUNT_LIMIT)
        begin
          nxt_sts = 1'b1;
        end
      end
      if (disable_lane_error_counter[g])
      begin
        nxt_dis = 1'b1;
      end
    end

    // Counter, disable and status registers
    always_ff @(posedge MCLK or negedge RSTN)
    begin
      if (!RSTN)
      begin
        cnt_ff <= COUNT_RESET;
        dis_ff <= 1'b0;
        sts_ff <= 1'b0;
      end
      else
      begin
        cnt_ff <= nxt_cnt;
        dis_ff <= nxt_dis;
        sts_ff <= nxt_sts;
      end
    end

    assign unexpected_ctrl_char_status[g] = sts_ff;
  end

  // ==========================================================
  // Lock history, checksum results and interrupt flags

  logic [NUM_LANES-1:0] prev_cg_ff;
  logic [NUM_LANES-1:0] nxt_prev_cg;
  logic [NUM_LANES-1:0] prev_fa_ff;
  logic [NUM_LANES-1:0] nxt_prev_fa;
  logic [NUM_LANES-1:0] prev_la_ff;
  logic [NUM_LANES-1:0] nxt_prev_la;
  logic [NUM_LANES-1:0] checksum_ok_ff;
  logic [NUM_LANES-1:0] nxt_checksum_ok;
  logic [3:0]           flags_ff;
  logic [3:0]           nxt_flags;
  logic [3:0]           flag_set;
  logic [3:0]           flag_clr;
  logic                 fa_lost;
  logic                 la_lost;

  // Loss is a falling lock; a lane that never locked raises nothing
  always_comb
  begin
    nxt_prev_cg = CODE_GROUP_LOCK;
    nxt_prev_fa = FRAME_ALIGNMENT_LOCK;
    nxt_prev_la = LANE_ALIGNMENT_LOCK;
    fa_lost     = |(prev_fa_ff & ~FRAME_ALIGNMENT_LOCK);
    la_lost     = |(prev_la_ff & ~LANE_ALIGNMENT_LOCK);
    // Result held until that lane computes its next checksum
    nxt_checksum_ok = (checksum_ok_ff & ~CHECKSUM_DONE)
                    | (CHECKSUM_OK & CHECKSUM_DONE);
    flag_set = '0;
    flag_set[IRQF_CODE_GROUP] = |(prev_cg_ff & ~CODE_GROUP_LOCK);
    flag_set[IRQF_FRAME]      = fa_lost;
    flag_set[IRQF_CHECKSUM]   = |(CHECKSUM_DONE & ~CHECKSUM_OK);
    flag_set[IRQF_LANE_ALIGN] = la_lost;
    // Bit 7 of a flag register only clears its interrupt
    flag_clr = '0;
    flag_clr[IRQF_CODE_GROUP] = wr_cg  && REG_WDATA[FLAG_CLEAR_BIT];
    flag_clr[IRQF_FRAME]      = wr_fa  && REG_WDATA[FLAG_CLEAR_BIT];
    flag_clr[IRQF_CHECKSUM]   = wr_chk && REG_WDATA[FLAG_CLEAR_BIT];
    flag_clr[IRQF_LANE_ALIGN] = wr_la  && REG_WDATA[FLAG_CLEAR_BIT];
    // A new failure in the clearing cycle survives
    nxt_flags = (flags_ff & ~flag_clr) | flag_set;
  end

  // History and flag registers
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      prev_cg_ff     <= '0;
      prev_fa_ff     <= '0;
      prev_la_ff     <= '0;
      checksum_ok_ff <= '0;
      flags_ff       <= '0;
    end
    else
    begin
      prev_cg_ff     <= nxt_prev_cg;
      prev_fa_ff     <= nxt_prev_fa;
      prev_la_ff     <= nxt_prev_la;
      checksum_ok_ff <= nxt_checksum_ok;
      flags_ff       <= nxt_flags;
    end
  end

  // ==========================================================
  // Interrupt and sync request outputs

  logic       irq_n_ff;
  logic       nxt_irq_n;
  logic       ucc_cause;
  logic       cg_cause;
  logic       resync_n_ff;
  logic       nxt_resync_n;
  logic       restart_ff;
  logic       nxt_restart;
  logic [3:0] pulse_cnt_ff;
  logic [3:0] nxt_pulse_cnt;

  // Request holds while any lane lacks code-group lock; an alignment
  // loss adds a fixed pulse so the transmitter restarts its sequence
  always_comb
  begin
    // Each cause is gated by its own enable; either one pulls the line low
    ucc_cause = BAD_CTRL_CHAR_IRQ_ENABLE && (|unexpected_ctrl_char_status);
    cg_cause  = CODE_GROUP_IRQ_ENABLE && flags_ff[IRQF_CODE_GROUP];
    nxt_irq_n = ~(ucc_cause || cg_cause);
    nxt_restart   = fa_lost;
    nxt_pulse_cnt = pulse_cnt_ff;
    // A second loss in mid-pulse starts the full pulse length again
    if (fa_lost || la_lost)
    begin
      nxt_pulse_cnt = RESYNC_PULSE_CYCLES;
    end
    else if (pulse_cnt_ff != 4'h0)
    begin
      nxt_pulse_cnt = pulse_cnt_ff - 4'h1;
    end
    nxt_resync_n = ~((|(~CODE_GROUP_LOCK)) || (nxt_pulse_cnt != 4'h0));
  end

  // Output registers; request asserted (low) out of reset
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      irq_n_ff     <= 1'b1;
      resync_n_ff  <= 1'b0;
      restart_ff   <= 1'b0;
      pulse_cnt_ff <= 4'h0;
    end
    else
    begin
      irq_n_ff     <= nxt_irq_n;
      resync_n_ff  <= nxt_resync_n;
      restart_ff   <= nxt_restart;
      pulse_cnt_ff <= nxt_pulse_cnt;
    end
  end

  // ==========================================================
  // Framing control and register read back

  logic [7:0] octets_ff;
  logic [7:0] nxt_octets;
  logic [7:0] octet_cnt_ff;
  logic [7:0] nxt_octet_cnt;
  logic [7:0] frame_len;
  logic       frame_start_ff;
  logic       nxt_frame_start;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;

  // Illegal frame sizes are kept for read back but frame as one octet,
  // so a bad write cannot stall the lane framing
  always_comb
  begin
    // Any value is stored; only the framing below checks legality
    nxt_octets = wr_ctrl ? REG_WDATA : octets_ff;
    frame_len  = ((octets_ff == OCTETS_TWO) || (octets_ff == OCTETS_FOUR))
               ? octets_ff : OCTETS_RESET;
    // A frame restart realigns the octet phase
    if (restart_ff || (octet_cnt_ff >= frame_len - 8'h01))
    begin
      nxt_octet_cnt = COUNT_RESET;
    end
    else
    begin
      nxt_octet_cnt = octet_cnt_ff + 8'h01;
    end
    nxt_frame_start = (nxt_octet_cnt == COUNT_RESET);
    // Read data holds between reads; unmapped reads return zero
    nxt_rdata = rdata_ff;
    if (REG_RD)
    begin
      unique case (REG_ADDR)
        ADDR_BAD_CTRL_CHAR: nxt_rdata = unexpected_ctrl_char_status;
        ADDR_CODE_GROUP:    nxt_rdata = CODE_GROUP_LOCK;
        ADDR_FRAME_ALIGN:   nxt_rdata = FRAME_ALIGNMENT_LOCK;
        ADDR_CHECKSUM:      nxt_rdata = checksum_ok_ff;
        ADDR_LANE_ALIGN:    nxt_rdata = LANE_ALIGNMENT_LOCK;
        ADDR_FRAMING_CTRL:  nxt_rdata = octets_ff;
        default:            nxt_rdata = READ_UNMAPPED;
      endcase
    end
  end

  // Framing and read data registers
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      octets_ff      <= OCTETS_RESET;
      octet_cnt_ff   <= COUNT_RESET;
      frame_start_ff <= 1'b0;
      rdata_ff       <= READ_UNMAPPED;
    end
    else
    begin
      octets_ff      <= nxt_octets;
      octet_cnt_ff   <= nxt_octet_cnt;
      frame_start_ff <= nxt_frame_start;
      rdata_ff       <= nxt_rdata;
    end
  end

  // ==========================================================
  // Outputs, all straight from flip-flops

  assign REG_RDATA                   = rdata_ff;
  assign IRQ_N                       = irq_n_ff;
  assign IRQ_FLAGS                   = flags_ff;
  assign UNEXPECTED_CTRL_CHAR_STATUS = unexpected_ctrl_char_status;
  assign LINK_RESYNC_REQUEST_OUT_N   = resync_n_ff;
  assign FRAME_RESTART               = restart_ff;
  assign OCTETS_PER_FRAME            = octets_ff;
  assign FRAME_START                 = frame_start_ff;

endmodule

// File: src/rx_status_pkg.sv
// What this block does
// - Lane status bit sets at error limit
// - Command bit 7 clears selected lane interrupt
// - Command bit 6 disables selected lane counter
// - Command bit 5 resets selected lane counter
// - Bits 2..0 pick the commanded lane
// - Report code-group lock per lane
// - Flag register bit 7 write clears interrupt
// - Lost code-group lock asserts sync request
// - Report live frame alignment per lane
// - Frame loss restarts synchronization automatically
// - Hold last checksum result per lane
// - Lane alignment bit, loss on sync request
// - Interrupt flags in bits 0, 1, 2, 3
// - Octets per frame resets to one
// - Masked bad-character limit pulls interrupt low
// - Masked code-group failure pulls interrupt low
package rx_status_pkg;

  // ==========================================================
  // Geometry
  localparam int          NUM_LANES  = 8;
  localparam int          ADDR_W     = 12;
  localparam int          DATA_W     = 8;
  localparam int          LANE_SEL_W = 3;

  // ==========================================================
  // Register offsets
  localparam logic [11:0] ADDR_BAD_CTRL_CHAR = 12'h46f;
  localparam logic [11:0] ADDR_CODE_GROUP    = 12'h470;
  localparam logic [11:0] ADDR_FRAME_ALIGN   = 12'h471;
  localparam logic [11:0] ADDR_CHECKSUM      = 12'h472;
  localparam logic [11:0] ADDR_LANE_ALIGN    = 12'h473;
  localparam logic [11:0] ADDR_FRAMING_CTRL  = 12'h476;

  // ==========================================================
  // Field positions
  localparam int          CMD_CLEAR_BIT   = 7;
  localparam int          CMD_DISABLE_BIT = 6;
  localparam int          CMD_RESET_BIT   = 5;
  localparam int          CMD_LANE_LSB    = 0;
  localparam int          FLAG_CLEAR_BIT  = 7;
  localparam int          IRQF_CODE_GROUP = 0;
  localparam int          IRQF_FRAME      = 1;
  localparam int          IRQF_CHECKSUM   = 2;
  localparam int          IRQF_LANE_ALIGN = 3;

  // ==========================================================
  // Values after reset and fixed values
  localparam logic [7:0]  OCTETS_RESET    = 8'h01;
  localparam logic [7:0]  OCTETS_TWO      = 8'h02;
  localparam logic [7:0]  OCTETS_FOUR     = 8'h04;
  localparam logic [7:0]  COUNT_RESET     = 8'h00;
  localparam logic [7:0]  COUNT_MAX       = 8'hff;
  localparam logic [7:0]  READ_UNMAPPED   = 8'h00;

  // ==========================================================
  // Timing: sync request pulse after alignment loss, 80 ns
  localparam int          CLK_PERIOD_NS      = 20;
  localparam int          RESYNC_PULSE_NS    = 80;
  localparam logic [3:0]  RESYNC_PULSE_CYCLES =
    4'((RESYNC_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

endpackage

// File: sim/rx_status_checker.sv
`timescale 1ns/1ns
// ==========================================================
// Port checks of the lane status monitor
module rx_status_checker
(
  input wire logic        MCLK,
  input wire logic        RSTN,
  input wire logic [11:0] REG_ADDR,
  input wire logic        REG_RD,
  input wire logic [7:0]  REG_RDATA,
  input wire logic [7:0]  CODE_GROUP_LOCK,
  input wire logic [7:0]  FRAME_ALIGNMENT_LOCK,
  input wire logic [7:0]  LANE_ALIGNMENT_LOCK,
  input wire logic [7:0]  CHECKSUM_DONE,
  input wire logic [7:0]  CHECKSUM_OK,
  input wire logic        BAD_CTRL_CHAR_IRQ_ENABLE,
  input wire logic        CODE_GROUP_IRQ_ENABLE,
  input wire logic        IRQ_N,
  input wire logic [3:0]  IRQ_FLAGS,
  input wire logic [7:0]  UNEXPECTED_CTRL_CHAR_STATUS,
  input wire logic        LINK_RESYNC_REQUEST_OUT_N,
  input wire logic        FRAME_RESTART
);
  // One domain; the $past guards keep the release edge from faking a fall
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RSTN);
  a_resync_cg_loss: assert property (!(&CODE_GROUP_LOCK) |=> !LINK_RESYNC_REQUEST_OUT_N)
    else $error("sync request missing after code-group loss");
  a_frame_restart: assert property ($past(RSTN) && |($past(FRAME_ALIGNMENT_LOCK)
    & ~FRAME_ALIGNMENT_LOCK) |=> FRAME_RESTART)
    else $error("no restart after frame alignment loss");
  a_align_resync_hold: assert property ($past(RSTN) && |($past(LANE_ALIGNMENT_LOCK)
    & ~LANE_ALIGNMENT_LOCK) |=> !LINK_RESYNC_REQUEST_OUT_N [*4])
    else $error("sync request too short after lane alignment loss");
  a_cg_flag_set: assert property ($past(RSTN) && |($past(CODE_GROUP_LOCK)
    & ~CODE_GROUP_LOCK) |=> IRQ_FLAGS[0])
    else $error("code-group flag not set");
  a_chk_flag_set: assert property (|(CHECKSUM_DONE & ~CHECKSUM_OK) |=> IRQ_FLAGS[2])
    else $error("checksum flag not set");
  a_la_flag_set: assert property ($past(RSTN) && |($past(LANE_ALIGNMENT_LOCK)
    & ~LANE_ALIGNMENT_LOCK) |=> IRQ_FLAGS[3])
    else $error("lane alignment flag not set");
  a_ucc_irq_low: assert property (BAD_CTRL_CHAR_IRQ_ENABLE
    && |UNEXPECTED_CTRL_CHAR_STATUS |=> !IRQ_N)
    else $error("interrupt not low for bad characters");
  a_cg_irq_low: assert property (CODE_GROUP_IRQ_ENABLE && IRQ_FLAGS[0] |=> !IRQ_N)
    else $error("interrupt not low for code-group loss");
  a_irq_quiet: assert property (!(BAD_CTRL_CHAR_IRQ_ENABLE && |UNEXPECTED_CTRL_CHAR_STATUS)
    && !(CODE_GROUP_IRQ_ENABLE && IRQ_FLAGS[0]) |=> IRQ_N)
    else $error("interrupt low without cause");
  a_cmd_read_status: assert property (REG_RD && REG_ADDR == 12'h46f
    |=> REG_RDATA == $past(UNEXPECTED_CTRL_CHAR_STATUS))
    else $error("command address read is not the status");
endmodule

// File: sim/lane_source_model.sv
`timescale 1ns/1ns
// ==========================================================
// Far-end transmitter lanes as seen by the deframers
module lane_source_model
(
  input wire logic [7:0] cg_up,
  input wire logic [7:0] fa_up,
  input wire logic [7:0] la_up,
  input wire logic [7:0] err_req,
  input wire logic [7:0] chk_req,
  input wire logic [7:0] chk_good,
  output logic     [7:0] cg_lock,
  output logic     [7:0] fa_lock,
  output logic     [7:0] la_lock,
  output logic     [7:0] bad_char,
  output logic     [7:0] chk_done,
  output logic     [7:0] chk_ok
);
  // Lock levels and one error count per high cycle
  assign cg_lock  = cg_up;
  assign fa_lock  = fa_up;
  assign la_lock  = la_up;
  assign bad_char = err_req;
  assign chk_done = chk_req;
  // Result is only valid with done; otherwise show the wrong value on purpose
  assign chk_ok   = chk_good ^ ~chk_req;
endmodule

// File: sim/tb_serial_link_rx_status_monitor.sv
`timescale 1ns/1ns
// ==========================================================
// Self-checking bench
module tb_serial_link_rx_status_monitor;
  logic        mclk, rstn, wr, rd, en_ucc, en_cg, irq_n, sync_n, restart, fstart;
  logic [11:0] addr;
  logic [3:0]  flags;
  logic [7:0]  wdata, rdata, limit, status, opf, cg_up, fa_up, la_up, err, chk, good;
  logic [7:0]  cg, fa, la, bad, cdone, cok;
  int          fails, tests_run;

  lane_source_model u_lane_source_model (.cg_up(cg_up), .fa_up(fa_up), .la_up(la_up),
    .err_req(err), .chk_req(chk), .chk_good(good), .cg_lock(cg), .fa_lock(fa),
    .la_lock(la), .bad_char(bad), .chk_done(cdone), .chk_ok(cok));
  serial_link_rx_status_monitor u_serial_link_rx_status_monitor (.MCLK(mclk), .RSTN(rstn),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
    .LANE_BAD_CTRL_CHAR(bad), .CODE_GROUP_LOCK(cg), .FRAME_ALIGNMENT_LOCK(fa),
    .CHECKSUM_DONE(cdone), .CHECKSUM_OK(cok), .LANE_ALIGNMENT_LOCK(la),
    .ERROR_COUNT_LIMIT(limit), .BAD_CTRL_CHAR_IRQ_ENABLE(en_ucc),
    .CODE_GROUP_IRQ_ENABLE(en_cg), .IRQ_N(irq_n), .IRQ_FLAGS(flags),
    .UNEXPECTED_CTRL_CHAR_STATUS(status), .LINK_RESYNC_REQUEST_OUT_N(sync_n),
    .FRAME_RESTART(restart), .OCTETS_PER_FRAME(opf), .FRAME_START(fstart));

  // 50 MHz clock
  always #10 mclk = ~mclk;

  // Shared helpers: compare, idle, register cycles, error bursts
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    check(rdata, exp);
  endtask
  task automatic burst(input logic [7:0] m, input int n);
    @(posedge mclk);
    err <= m;
    repeat (n) @(posedge mclk);
    err <= 8'h00;
    cyc(2);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    check(opf, 8'h01);
    check(status, 8'h00);
    check(8'(irq_n), 8'h01);
    check(8'(sync_n), 8'h01);
    rd_chk(12'h476, 8'h01);
    rd_chk(12'h474, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_ucc;
    burst(8'h04, 3);
    check(status, 8'h04);
    check(8'(irq_n), 8'h00);
    rd_chk(12'h46f, 8'h04);
    wr_reg(12'h46f, 8'h83);
    check(status, 8'h04);
    wr_reg(12'h46f, 8'he2);
    check(status, 8'h00);
    cyc(1);
    check(8'(irq_n), 8'h01);
    burst(8'h04, 3);
    check(status, 8'h00);
    wr_reg(12'h46f, 8'h22);
    burst(8'h04, 3);
    check(status, 8'h04);
    @(posedge mclk);
    en_ucc <= 1'b0;
    cyc(2);
    check(8'(irq_n), 8'h01);
    @(posedge mclk);
    en_ucc <= 1'b1;
    wr_reg(12'h46f, 8'h82);
    $display("test bad characters done");
  endtask
  task automatic t_cg;
    @(posedge mclk);
    cg_up <= 8'hdf;
    cyc(2);
    check(8'(sync_n), 8'h00);
    check(8'(flags[0]), 8'h01);
    check(8'(irq_n), 8'h00);
    rd_chk(12'h470, 8'hdf);
    @(posedge mclk);
    cg_up <= 8'hff;
    wr_reg(12'h470, 8'h80);
    check(8'(flags[0]), 8'h00);
    rd_chk(12'h470, 8'hff);
    check(8'(irq_n), 8'h01);
    check(8'(sync_n), 8'h01);
    $display("test code group done");
  endtask
  task automatic t_frame;
    @(posedge mclk);
    fa_up <= 8'hfd;
    cyc(1);
    check(8'(restart), 8'h01);
    check(8'(sync_n), 8'h00);
    check(8'(flags[1]), 8'h01);
    rd_chk(12'h471, 8'hfd);
    check(8'(restart), 8'h00);
    @(posedge mclk);
    fa_up <= 8'hff;
    wr_reg(12'h471, 8'h80);
    check(8'(flags[1]), 8'h00);
    $display("test frame done");
  endtask
  task automatic t_chk;
    @(posedge mclk);
    chk <= 8'hff;
    good <= 8'hff;
    @(posedge mclk);
    chk <= 8'h10;
    good <= 8'h00;
    @(posedge mclk);
    chk <= 8'h00;
    cyc(1);
    check(8'(flags[2]), 8'h01);
    rd_chk(12'h472, 8'hef);
    wr_reg(12'h472, 8'h80);
    check(8'(flags[2]), 8'h00);
    $display("test checksum done");
  endtask
  task automatic t_lane;
    @(posedge mclk);
    la_up <= 8'hfe;
    cyc(2);
    check(8'(sync_n), 8'h00);
    check(8'(flags[3]), 8'h01);
    rd_chk(12'h473, 8'hfe);
    cyc(4);
    check(8'(sync_n), 8'h01);
    @(posedge mclk);
    la_up <= 8'hff;
    wr_reg(12'h473, 8'h80);
    check(8'(flags[3]), 8'h00);
    $display("test lane alignment done");
  endtask
  task automatic t_octets;
    logic [7:0] f;
    int         n;
    // Sizes 2, 4, 1, then the illegal 3, which must frame as one octet
    for (int i = 0; i < 4; i++)
    begin
      f = (i == 2) ? 8'h01 : (i == 3) ? 8'h03 : 8'(2 << i);
      wr_reg(12'h476, f);
      rd_chk(12'h476, f);
      cyc(4);
      n = 0;
      repeat (8)
      begin
        @(posedge mclk);
        #1;
        if (fstart === 1'b1)
          n++;
      end
      check(8'(n), 8'((f == 8'h03) ? 8 : 8 / f));
    end
    $display("test framing done");
  endtask

  // Verdict in one place
  task automatic tally_and_finish;
    $display("tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Hang guard, far beyond the 143 cycles the run needs
  initial
  begin
    #100000;
    fails++;
    tally_and_finish();
  end

  // Main sequence
  initial
  begin
    {mclk, rstn, wr, rd, addr, wdata, err, chk, good} = '0;
    {limit, en_ucc, en_cg, cg_up, fa_up, la_up} = {8'h03, 2'b11, 24'hffffff};
    {fails, tests_run} = '0;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    cyc(2);
    t_reset();
    t_ucc();
    t_cg();
    t_frame();
    t_chk();
    t_lane();
    t_octets();
    tally_and_finish();
  end
endmodule

// Checker beside the design's ports
bind serial_link_rx_status_monitor rx_status_checker u_rx_status_checker (.MCLK(MCLK),
  .RSTN(RSTN), .REG_ADDR(REG_ADDR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .CODE_GROUP_LOCK(CODE_GROUP_LOCK), .FRAME_ALIGNMENT_LOCK(FRAME_ALIGNMENT_LOCK),
  .LANE_ALIGNMENT_LOCK(LANE_ALIGNMENT_LOCK), .CHECKSUM_DONE(CHECKSUM_DONE),
  .CHECKSUM_OK(CHECKSUM_OK), .BAD_CTRL_CHAR_IRQ_ENABLE(BAD_CTRL_CHAR_IRQ_ENABLE),
  .CODE_GROUP_IRQ_ENABLE(CODE_GROUP_IRQ_ENABLE), .IRQ_N(IRQ_N), .IRQ_FLAGS(IRQ_FLAGS),
  .UNEXPECTED_CTRL_CHAR_STATUS(UNEXPECTED_CTRL_CHAR_STATUS),
  .LINK_RESYNC_REQUEST_OUT_N(LINK_RESYNC_REQUEST_OUT_N), .FRAME_RESTART(FRAME_RESTART));
